// ===== hw/smt_pkg.sv
// Package: register map, field positions, reset values and codes of the measurement timer
package smt_pkg;
  // Register byte addresses on the APB bus
  localparam logic [7:0]  OFF_CON0   = 8'h00;
  localparam logic [7:0]  OFF_CON1   = 8'h04;
  localparam logic [7:0]  OFF_STAT   = 8'h08;
  localparam logic [7:0]  OFF_CLK    = 8'h0c;
  localparam logic [7:0]  OFF_WIN    = 8'h10;
  localparam logic [7:0]  OFF_SIG    = 8'h14;
  localparam logic [7:0]  OFF_TMRL   = 8'h18;
  localparam logic [7:0]  OFF_TMRH   = 8'h1c;
  localparam logic [7:0]  OFF_TMRU   = 8'h20;
  localparam logic [7:0]  OFF_CPRL   = 8'h24;
  localparam logic [7:0]  OFF_CPRH   = 8'h28;
  localparam logic [7:0]  OFF_CPRU   = 8'h2c;
  localparam logic [7:0]  OFF_CPWL   = 8'h30;
  localparam logic [7:0]  OFF_CPWH   = 8'h34;
  localparam logic [7:0]  OFF_CPWU   = 8'h38;
  localparam logic [7:0]  OFF_PRL    = 8'h3c;
  localparam logic [7:0]  OFF_PRH    = 8'h40;
  localparam logic [7:0]  OFF_PRU    = 8'h44;
  localparam logic [7:0]  OFF_MISC   = 8'h48;
  // Field positions
  localparam int          CON0_EN    = 7;
  localparam int          CON0_STP   = 5;
  localparam int          CON0_WINDOW_POLARITY  = 4;
  localparam int          CON0_SIGNAL_POLARITY  = 3;
  localparam int          CON0_CLOCK_POLARITY  = 2;
  localparam int          CON1_GO    = 7;
  localparam int          CON1_REP   = 6;
  localparam int          REQ_CPR    = 2;
  localparam int          REQ_CPW    = 1;
  localparam int          REQ_RST    = 0;
  localparam int          MISC_NARROW = 0;
  // Writable masks and reset values
  localparam logic [7:0]  CON0_MASK  = 8'hbf;
  localparam logic [7:0]  CON1_MASK  = 8'hcf;
  localparam logic [7:0]  CLK_MASK   = 8'h07;
  localparam logic [7:0]  SEL_MASK   = 8'h1f;
  localparam logic [7:0]  MISC_MASK  = 8'h01;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [23:0] PR_RST     = 24'hffffff;
  // Mode codes
  localparam logic [3:0]  MD_TIMER   = 4'h0;
  localparam logic [3:0]  MD_GATED   = 4'h1;
  localparam logic [3:0]  MD_PERDUTY = 4'h2;
  localparam logic [3:0]  MD_HILO    = 4'h3;
  localparam logic [3:0]  MD_WINMEAS = 4'h4;
  localparam logic [3:0]  MD_GWINMEAS = 4'h5;
  localparam logic [3:0]  MD_TOF     = 4'h6;
  localparam logic [3:0]  MD_CAPTURE = 4'h7;
  localparam logic [3:0]  MD_COUNTER = 4'h8;
  localparam logic [3:0]  MD_GCOUNTER = 4'h9;
  localparam logic [3:0]  MD_WCOUNTER = 4'ha;
  // Count clock source codes
  localparam logic [2:0]  CS_INSTR   = 3'h0;
  localparam logic [2:0]  CS_SYS     = 3'h1;
  localparam logic [2:0]  CS_HF      = 3'h2;
  localparam logic [2:0]  CS_LF      = 3'h3;
  localparam logic [2:0]  CS_MID     = 3'h4;
  localparam logic [2:0]  CS_MID16   = 3'h5;
  localparam logic [2:0]  CS_SEC     = 3'h6;
  // Highest valid window and signal source codes
  localparam logic [4:0]  WIN_LAST   = 5'h12;
  localparam logic [4:0]  SIG_LAST   = 5'h10;
  // Dividers
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
  localparam logic [3:0]  MID_DIV_LAST   = 4'hf;
endpackage

// ===== hw/smt_timer.sv
// Signal measurement timer: APB register file, source selection, prescaler and 24-bit counter
`timescale 1ns/1ps
`default_nettype none
// Operation
// - 24-bit up-counter clocked through selectable clock and gating logic.
// - Optional narrow mode makes the counter behave as 16 bits.
// - Clearing enable resets internal state but keeps register contents.
// - On counter equal period, next count raises match, holds or zeroes.
// - Window polarity picks active-high rising or active-low falling window.
// - Signal polarity picks active-high rising or active-low falling signal.
// - Clock polarity picks rising or falling edge of selected oscillator clock; system and instruction clocks ignore it.
// - Prescaler divides the count clock by 1, 2, 4 or 8.
// - Go bit enables counting and acquisition; hardware may clear it.
// - Repeat bit selects continuous or single acquisition.
// - Four-bit mode field selects one of eleven modes, rest reserved.
// - Period capture request copies counter, then clears itself.
// - Width capture request copies counter, then clears itself.
// - Counter reset request zeroes counter, then clears itself.
// - Counting status reads one while the counter increments.
// - Window status reads the present window state.
// - Acquisition status reads one while an acquisition runs.
// - Three-bit clock select picks the count clock source.
// - Separate event outputs for period match and acquisition complete.
// - Holds 24-bit period capture, width capture and period match registers.
// - Counter readable and writable as low, high and upper bytes.
// - Five-bit signal select picks the signal source, high codes reserved.
// - Period match register resets to all ones.
module smt_timer
  import smt_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int WIN_N = 19,
  parameter int SIG_N = 17
)(
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             highFreqOscillator,
  input  wire logic             lowFreqOscillator,
  input  wire logic             midFreqOscillator,
  input  wire logic             secondaryOscillator,
  input  wire logic             windowPin,
  input  wire logic [WIN_N-1:1] windowSources,
  input  wire logic             signalPin,
  input  wire logic [SIG_N-1:1] signalSources,
  output logic                  periodMatchIrq,
  output logic                  acqDoneIrq
);

  logic [7:0]       con0_reg;
  logic [7:0]       con1_reg;
  logic [7:0]       clk_reg;
  logic [7:0]       winSel_reg;
  logic [7:0]       sigSel_reg;
  logic [7:0]       misc_reg;
  logic [2:0]       req_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] pr_reg;
  logic [CNT_W-1:0] cpr_reg;
  logic [CNT_W-1:0] cpw_reg;
  logic [31:0]      rdata_next;
  logic             rerr_next;
  logic             ready_reg;
  logic             err_reg;
  logic [31:0]      rdata_reg;
  logic             matchIrq_reg;
  logic             doneIrq_reg;

  function automatic logic [CNT_W-1:0] setByte(input logic [CNT_W-1:0] v, input int idx, input logic [7:0] b);
    logic [CNT_W-1:0] r;
    r = v;
    r[idx*8 +: 8] = b;
    return r;
  endfunction

  function automatic logic [7:0] getByte(input logic [CNT_W-1:0] v, input int idx);
    return v[idx*8 +: 8];
  endfunction

  // Bus
  logic access;
  logic wrStrobe;
  assign access   = psel & penable;
  assign wrStrobe = access & ready_reg & pwrite;
  assign pready   = ready_reg;
  assign prdata   = rdata_reg;
  assign pslverr  = err_reg;

  function automatic logic wrHit(input logic [7:0] off);
    return wrStrobe && (paddr == off);
  endfunction

  logic en;
  logic go;
  logic narrow;
  logic tmrWr;
  assign en     = con0_reg[CON0_EN];
  assign go     = con1_reg[CON1_GO];
  assign narrow = misc_reg[MISC_NARROW];
  assign tmrWr  = wrHit(OFF_TMRL) | wrHit(OFF_TMRH) | wrHit(OFF_TMRU);

  // Synchronisers: stage A feeds only stage B
  logic [3:0]       clkA, clkB;
  logic [WIN_N-1:0] winA, winB;
  logic [SIG_N-1:0] sigA, sigB;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !en)
    begin
      clkA <= '0;
      clkB <= '0;
      winA <= '0;
      winB <= '0;
      sigA <= '0;
      sigB <= '0;
    end
    else
    begin
      clkA <= {secondaryOscillator, midFreqOscillator, lowFreqOscillator, highFreqOscillator};
      clkB <= clkA;
      winA <= {windowSources, windowPin};
      winB <= winA;
      sigA <= {signalSources, signalPin};
      sigB <= sigA;
    end
  end

  // Source selection; reserved codes give an idle level
  logic winLevel;
  logic sigLevel;
  logic winAct;
  logic sigAct;
  assign winLevel = (winSel_reg[4:0] <= WIN_LAST) ? winB[winSel_reg[4:0]] : 1'b0;
  assign sigLevel = (sigSel_reg[4:0] <= SIG_LAST) ? sigB[sigSel_reg[4:0]] : 1'b0;
  assign winAct   = winLevel ^ con0_reg[CON0_WINDOW_POLARITY];
  assign sigAct   = sigLevel ^ con0_reg[CON0_SIGNAL_POLARITY];

  // Count clock: internal state restarts whenever enable is low
  logic [1:0] instrDiv;
  logic [3:0] midDiv;
  logic       midPrev;
  logic       srcPrev;
  logic       winPrev;
  logic       sigPrev;
  logic [2:0] psCnt;
  logic       srcLevel;
  logic       srcEdge;
  logic       tick;
  logic [2:0] psLast;
  always_comb
  begin
    srcLevel = 1'b0;
    srcEdge  = 1'b0;
    case (clk_reg[2:0])
      CS_HF:    srcLevel = clkB[0];
      CS_LF:    srcLevel = clkB[1];
      CS_MID:   srcLevel = clkB[2];
      CS_MID16: srcLevel = midDiv[3];
      CS_SEC:   srcLevel = clkB[3];
      default:  srcLevel = 1'b0;
    endcase
    if (clk_reg[2:0] == CS_SYS)
      srcEdge = 1'b1;
    else if (clk_reg[2:0] == CS_INSTR)
      srcEdge = (instrDiv == INSTR_DIV_LAST);
    else if (con0_reg[CON0_CLOCK_POLARITY])
      srcEdge = srcPrev & ~srcLevel;
    else
      srcEdge = ~srcPrev & srcLevel;
  end

  assign psLast = {con0_reg[1] & con0_reg[0], con0_reg[1], con0_reg[1] | con0_reg[0]};
  // Compare with >= so that lowering the prescale while running does not stall for a full wrap
  assign tick   = srcEdge && (psCnt >= psLast);

  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !en)
    begin
      instrDiv <= '0;
      midDiv   <= '0;
      midPrev  <= 1'b0;
      srcPrev  <= 1'b0;
      winPrev  <= 1'b0;
      sigPrev  <= 1'b0;
      psCnt    <= '0;
    end
    else
    begin
      instrDiv <= instrDiv + 2'h1;
      midPrev  <= clkB[2];
      if (clkB[2] && !midPrev)
        midDiv <= (midDiv == MID_DIV_LAST) ? 4'h0 : midDiv + 4'h1;
      srcPrev <= srcLevel;
      winPrev <= winAct;
      sigPrev <= sigAct;
      if (srcEdge)
        psCnt <= (psCnt >= psLast) ? 3'h0 : psCnt + 3'h1;
    end
  end

  logic winRise, winFall, sigRise, sigFall;
  assign winRise = winAct & ~winPrev;
  assign winFall = ~winAct & winPrev;
  assign sigRise = sigAct & ~sigPrev;
  assign sigFall = ~sigAct & sigPrev;

  // Mode decode
  logic [3:0] mode;
  logic       incEv;
  logic       restart;
  logic       cprLoad;
  logic       cpwLoad;
  logic       acqEv;
  assign mode = con1_reg[3:0];
  always_comb
  begin
    incEv   = 1'b0;
    restart = 1'b0;
    cprLoad = 1'b0;
    cpwLoad = 1'b0;
    case (mode)
      MD_TIMER:    incEv = tick;
      MD_GATED:
      begin
        incEv   = tick & sigAct;
        cpwLoad = sigFall;
      end
      MD_PERDUTY:
      begin
        incEv   = tick;
        restart = sigRise;
        cprLoad = sigRise;
        cpwLoad = sigFall;
      end
      MD_HILO:
      begin
        incEv   = tick;
        restart = sigRise | sigFall;
        cprLoad = sigRise;
        cpwLoad = sigFall;
      end
      MD_WINMEAS:
      begin
        incEv   = tick;
        restart = winRise;
        cprLoad = winRise;
      end
      MD_GWINMEAS:
      begin
        incEv   = tick & sigAct;
        restart = winRise;
        cpwLoad = winRise;
      end
      MD_TOF:
      begin
        incEv   = tick;
        restart = winRise;
        cprLoad = winRise;
        cpwLoad = sigRise;
      end
      MD_CAPTURE:
      begin
        incEv   = tick;
        cprLoad = sigRise;
        cpwLoad = winRise;
      end
      MD_COUNTER:  incEv = sigRise;
      MD_GCOUNTER:
      begin
        incEv   = sigRise & winAct;
        cpwLoad = winFall;
      end
      MD_WCOUNTER:
      begin
        incEv   = sigRise;
        restart = winRise;
        cprLoad = winRise;
      end
      default:     incEv = 1'b0;
    endcase
  end

  logic run;
  logic match;
  logic countEv;
  logic doneEv;
  assign run     = en & go;
  assign match   = narrow ? (cnt_reg[15:0] == pr_reg[15:0]) : (cnt_reg == pr_reg);
  assign countEv = run & incEv & ~restart;
  assign acqEv   = (mode == MD_PERDUTY || mode == MD_HILO) ? sigRise : (cprLoad | cpwLoad);
  assign doneEv  = run & acqEv;

  always_comb
  begin
    cnt_next = cnt_reg + 1'b1;
    if (narrow)
      cnt_next = {{(CNT_W-16){1'b0}}, cnt_reg[15:0] + 16'h1};
    if (match)
      cnt_next = con0_reg[CON0_STP] ? cnt_reg : '0;
  end

  // Counter: software byte writes win over hardware
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (wrHit(OFF_TMRL))
      cnt_reg <= setByte(cnt_reg, 0, pwdata[7:0]);
    else if (wrHit(OFF_TMRH))
      cnt_reg <= setByte(cnt_reg, 1, pwdata[7:0]);
    else if (wrHit(OFF_TMRU))
      cnt_reg <= setByte(cnt_reg, 2, pwdata[7:0]);
    else if (req_reg[REQ_RST])
      cnt_reg <= '0;
    else if (run && restart)
      cnt_reg <= '0;
    else if (countEv)
      cnt_reg <= cnt_next;
  end

  // Capture registers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      cpr_reg <= '0;
      cpw_reg <= '0;
    end
    else
    begin
      if (req_reg[REQ_CPR] || (run && cprLoad))
        cpr_reg <= cnt_reg;
      if (req_reg[REQ_CPW] || (run && cpwLoad))
        cpw_reg <= cnt_reg;
    end
  end

  // Event outputs, registered; match stays high on every count while the counter holds at period
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      matchIrq_reg <= 1'b0;
      doneIrq_reg  <= 1'b0;
    end
    else
    begin
      matchIrq_reg <= countEv & match;
      doneIrq_reg  <= doneEv;
    end
  end
  assign periodMatchIrq = matchIrq_reg;
  assign acqDoneIrq     = doneIrq_reg;

  // Control registers; a go written in the completing cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      con0_reg   <= CTRL_RST;
      con1_reg   <= CTRL_RST;
      clk_reg    <= CTRL_RST;
      winSel_reg <= CTRL_RST;
      sigSel_reg <= CTRL_RST;
      misc_reg   <= CTRL_RST;
      pr_reg     <= PR_RST;
    end
    else
    begin
      if (wrHit(OFF_CON0))
        con0_reg <= pwdata[7:0] & CON0_MASK;
      if (wrHit(OFF_CON1))
        con1_reg <= pwdata[7:0] & CON1_MASK;
      else if (doneEv && !con1_reg[CON1_REP])
        con1_reg[CON1_GO] <= 1'b0;
      if (wrHit(OFF_CLK))
        clk_reg <= pwdata[7:0] & CLK_MASK;
      if (wrHit(OFF_WIN))
        winSel_reg <= pwdata[7:0] & SEL_MASK;
      if (wrHit(OFF_SIG))
        sigSel_reg <= pwdata[7:0] & SEL_MASK;
      if (wrHit(OFF_MISC))
        misc_reg <= pwdata[7:0] & MISC_MASK;
      if (wrHit(OFF_PRL))
        pr_reg <= setByte(pr_reg, 0, pwdata[7:0]);
      else if (wrHit(OFF_PRH))
        pr_reg <= setByte(pr_reg, 1, pwdata[7:0]);
      else if (wrHit(OFF_PRU))
        pr_reg <= setByte(pr_reg, 2, pwdata[7:0]);
    end
  end

  // Requests complete in one cycle; a new set in that cycle survives
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      req_reg <= '0;
    else if (wrHit(OFF_STAT))
      req_reg <= pwdata[7:5];
    else
      req_reg <= '0;
  end

  logic tsBit, wsBit, asBit;
  assign tsBit = countEv | (run && (mode == MD_TIMER || (mode == MD_GATED && sigAct)));
  assign wsBit = en & winAct;
  assign asBit = run;

  logic rstReqSet;
  assign rstReqSet = wrHit(OFF_STAT) & pwdata[5];

  // Read mux; unmapped addresses answer with an error
  always_comb
  begin
    rdata_next = '0;
    rerr_next  = 1'b0;
    if (paddr == OFF_CON0)
      rdata_next[7:0] = con0_reg;
    else if (paddr == OFF_CON1)
      rdata_next[7:0] = con1_reg;
    else if (paddr == OFF_STAT)
      rdata_next[7:0] = {req_reg, 2'b00, tsBit, wsBit, asBit};
    else if (paddr == OFF_CLK)
      rdata_next[7:0] = clk_reg;
    else if (paddr == OFF_WIN)
      rdata_next[7:0] = winSel_reg;
    else if (paddr == OFF_SIG)
      rdata_next[7:0] = sigSel_reg;
    else if (paddr == OFF_TMRL)
      rdata_next[7:0] = getByte(cnt_reg, 0);
    else if (paddr == OFF_TMRH)
      rdata_next[7:0] = getByte(cnt_reg, 1);
    else if (paddr == OFF_TMRU)
      rdata_next[7:0] = getByte(cnt_reg, 2);
    else if (paddr == OFF_CPRL)
      rdata_next[7:0] = getByte(cpr_reg, 0);
    else if (paddr == OFF_CPRH)
      rdata_next[7:0] = getByte(cpr_reg, 1);
    else if (paddr == OFF_CPRU)
      rdata_next[7:0] = getByte(cpr_reg, 2);
    else if (paddr == OFF_CPWL)
      rdata_next[7:0] = getByte(cpw_reg, 0);
    else if (paddr == OFF_CPWH)
      rdata_next[7:0] = getByte(cpw_reg, 1);
    else if (paddr == OFF_CPWU)
      rdata_next[7:0] = getByte(cpw_reg, 2);
    else if (paddr == OFF_PRL)
      rdata_next[7:0] = getByte(pr_reg, 0);
    else if (paddr == OFF_PRH)
      rdata_next[7:0] = getByte(pr_reg, 1);
    else if (paddr == OFF_PRU)
      rdata_next[7:0] = getByte(pr_reg, 2);
    else if (paddr == OFF_MISC)
      rdata_next[7:0] = misc_reg;
    else
      rerr_next = 1'b1;
  end

  // One wait state so read data comes from a flop
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= '0;
    end
    else if (access && !ready_reg)
    begin
      ready_reg <= 1'b1;
      err_reg   <= rerr_next;
      rdata_reg <= pwrite ? 32'h0 : rdata_next;
    end
    else
    begin
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
    end
  end

  chk_period_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    countEv && match && con0_reg[CON0_STP] && !tmrWr && !req_reg[REQ_RST] |=> cnt_reg == $past(cnt_reg))
    else $error("counter did not hold at period");
  chk_period_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    countEv && match && !con0_reg[CON0_STP] && !tmrWr && !req_reg[REQ_RST] |=> cnt_reg == '0 ##1 1)
    else $error("counter did not wrap at period");
  chk_match_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
    periodMatchIrq == ($past(countEv) && $past(match)))
    else $error("period event without cause");
  chk_go_freeze: assert property (@(posedge sys_clk) disable iff (!nrst)
    !run && !tmrWr && !req_reg[REQ_RST] |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved while stopped");
  chk_single_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
    doneEv && !con1_reg[CON1_REP] && !wrHit(OFF_CON1) |=> !go && acqDoneIrq)
    else $error("single acquisition left go set");
  chk_reset_req: assert property (@(posedge sys_clk) disable iff (!nrst)
    req_reg[REQ_RST] && !tmrWr |=> cnt_reg == '0 && (req_reg[REQ_RST] == $past(rstReqSet)))
    else $error("manual reset did not complete");
  chk_cpr_update: assert property (@(posedge sys_clk) disable iff (!nrst)
    req_reg[REQ_CPR] |=> cpr_reg == $past(cnt_reg))
    else $error("period capture not updated");
  chk_enable_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(en) |-> pr_reg == $past(pr_reg) && !tsBit && !asBit)
    else $error("disable disturbed registers or status");
  chk_narrow_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    narrow && countEv && !match && cnt_reg[15:0] == 16'hffff && !tmrWr |=> cnt_reg[15:0] == 16'h0000)
    else $error("narrow counter did not wrap at 16 bits");

endmodule
`default_nettype wire

// ===== verif/smt_src_model.sv
// Far-side model: free-running oscillators, peripheral outputs and the two input pins
`timescale 1ns/1ps
`default_nettype none
module smt_src_model (
  input  wire logic        sys_clk,
  input  wire logic        sigLevel,
  input  wire logic        winLevel,
  output logic             hfOsc,
  output logic             lfOsc,
  output logic             midOsc,
  output logic             secOsc,
  output logic             winPinOut,
  output logic [18:1]      winSrc,
  output logic             sigPinOut,
  output logic [16:1]      sigSrc
);
  logic [7:0] phaseCnt_reg = 8'h00;
  // Oscillators run free; other peripheral outputs keep changing so stale values never look stable
  always_ff @(posedge sys_clk)
    phaseCnt_reg <= phaseCnt_reg + 8'h01;
  assign hfOsc     = phaseCnt_reg[0];
  assign midOsc    = phaseCnt_reg[2];
  assign lfOsc     = phaseCnt_reg[4];
  assign secOsc    = phaseCnt_reg[5];
  assign winSrc    = {3{phaseCnt_reg[5:0]}};
  assign sigSrc    = {phaseCnt_reg, ~phaseCnt_reg};
  assign winPinOut = winLevel;
  assign sigPinOut = sigLevel;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Testbench: APB register checks and measurement scenarios for the timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smt_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        sigLvl  = 1'b0;
  logic        winLvl  = 1'b0;
  logic [31:0] prdata, q, q0;
  logic        pready, pslverr, pmIrq, acqIrq, hf, lf, mid, sec, winPin, sigPin, e;
  logic [18:1] winSrc;
  logic [16:1] sigSrc;
  int          errors = 0;
  int          num_checks = 0;
  int          pmCount = 0;
  int          acqCount = 0;
  localparam logic [7:0] RA[11] = '{OFF_CON0, OFF_CON1, OFF_STAT, OFF_CLK, OFF_WIN, OFF_SIG,
                                    OFF_PRL, OFF_PRH, OFF_PRU, OFF_TMRL, OFF_CPRL};
  localparam logic [7:0] RV[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
  localparam logic [7:0] MA[6] = '{OFF_CON0, OFF_CON1, OFF_CLK, OFF_WIN, OFF_SIG, OFF_MISC};
  localparam logic [7:0] MV[6] = '{8'hbf, 8'hcf, 8'h07, 8'h1f, 8'h1f, 8'h01};
  // Clock source, prescale code and count gained over 24 system clocks
  localparam logic [7:0] PC[5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
  localparam logic [7:0] PP[5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
  localparam logic [7:0] PD[5] = '{8'd6, 8'd24, 8'd12, 8'd6, 8'd3};

  always #20 sys_clk = ~sys_clk;

  smt_timer DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .highFreqOscillator(hf), .lowFreqOscillator(lf), .midFreqOscillator(mid), .secondaryOscillator(sec),
    .windowPin(winPin), .windowSources(winSrc), .signalPin(sigPin), .signalSources(sigSrc),
    .periodMatchIrq(pmIrq), .acqDoneIrq(acqIrq));

  smt_src_model src (.sys_clk(sys_clk), .sigLevel(sigLvl), .winLevel(winLvl), .hfOsc(hf), .lfOsc(lf),
    .midOsc(mid), .secOsc(sec), .winPinOut(winPin), .winSrc(winSrc), .sigPinOut(sigPin), .sigSrc(sigSrc));

  // Event outputs are counted at every edge; a match held at period counts once per cycle it stays high
  always @(posedge sys_clk)
  begin
    if (pmIrq === 1'b1)
      pmCount <= pmCount + 1;
    if (acqIrq === 1'b1)
      acqCount <= acqCount + 1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Answer is looked at mid-cycle where it has settled; it stands until the completing edge
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      check("pready", 32'h0, 32'h1);
    rq = prdata;
    re = pslverr;
    @(posedge sys_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d}, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(nm, q, {24'h0, exp});
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    summarize();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 11; i++)
      rc("reset value", RA[i], RV[i]);
    for (int i = 0; i < 6; i++)
    begin
      wr(MA[i], 8'hff);
      rc("writable bits", MA[i], MV[i]);
      wr(MA[i], 8'h00);
    end
    xfer(1'b1, 8'h4c, 32'hff, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    rd(8'h4c);
    check("unmapped data", q, 32'h0);
    // Reads spaced 24 clocks apart; the low byte gain is 24 over the total division
    for (int i = 0; i < 5; i++)
    begin
      wr(OFF_CON1, 8'h00);
      wr(OFF_CLK, PC[i]);
      wr(OFF_CON0, 8'h80 | PP[i]);
      wr(OFF_CON1, 8'h80);
      rd(OFF_TMRL);
      q0 = q;
      repeat (20) @(posedge sys_clk);
      rd(OFF_TMRL);
      check("count gain", (q - q0) & 32'hff, {24'h0, PD[i]});
      rd(OFF_STAT);
      check("counting status", q & 32'h4, 32'h4);
    end
    wr(OFF_CON1, 8'h00);
    rd(OFF_STAT);
    check("stopped status", q & 32'h4, 32'h0);
    rd(OFF_TMRL);
    q0 = q;
    repeat (10) @(posedge sys_clk);
    rc("held count", OFF_TMRL, q0[7:0]);
    wr(OFF_CON0, 8'h00);
    rc("clock select kept", OFF_CLK, 8'h01);
    rc("count kept", OFF_TMRL, q0[7:0]);
    wr(OFF_CON0, 8'h80);
    wr(OFF_TMRL, 8'h33);
    wr(OFF_TMRH, 8'h00);
    wr(OFF_TMRU, 8'h00);
    rc("count byte write", OFF_TMRL, 8'h33);
    wr(OFF_STAT, 8'h80);
    rc("period capture", OFF_CPRL, 8'h33);
    wr(OFF_STAT, 8'h40);
    rc("width capture", OFF_CPWL, 8'h33);
    wr(OFF_STAT, 8'h20);
    rc("counter reset", OFF_TMRL, 8'h00);
    rd(OFF_STAT);
    check("requests cleared", q & 32'he0, 32'h0);
    wr(OFF_CON1, 8'h8b);
    repeat (10) @(posedge sys_clk);
    rc("reserved mode", OFF_TMRL, 8'h00);
    wr(OFF_CON1, 8'h00);
    wr(OFF_PRL, 8'h05);
    wr(OFF_PRH, 8'h00);
    wr(OFF_PRU, 8'h00);
    wr(OFF_CON0, 8'ha0);
    wr(OFF_CON1, 8'h80);
    repeat (30) @(posedge sys_clk);
    rc("halt at period", OFF_TMRL, 8'h05);
    check("match event", {31'h0, pmCount != 0}, 32'h1);
    wr(OFF_CON0, 8'h80);
    repeat (30) @(posedge sys_clk);
    rd(OFF_TMRL);
    check("wrap at period", {31'h0, q <= 32'h5}, 32'h1);
    wr(OFF_CON1, 8'h00);
    wr(OFF_PRU, 8'hff);
    wr(OFF_MISC, 8'h01);
    wr(OFF_TMRL, 8'hff);
    wr(OFF_TMRH, 8'hff);
    wr(OFF_TMRU, 8'h00);
    wr(OFF_CON1, 8'h80);
    repeat (5) @(posedge sys_clk);
    wr(OFF_CON1, 8'h00);
    rc("narrow upper", OFF_TMRU, 8'h00);
    wr(OFF_MISC, 8'h00);
    winLvl <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(OFF_STAT);
    check("window open", q & 32'h2, 32'h2);
    wr(OFF_CON0, 8'h90);
    repeat (6) @(posedge sys_clk);
    rd(OFF_STAT);
    check("window inverted", q & 32'h2, 32'h0);
    winLvl <= 1'b0;
    wr(OFF_CON0, 8'h80);
    wr(OFF_CON1, 8'h87);
    repeat (6) @(posedge sys_clk);
    sigLvl <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("acquisition event", acqCount, 32'h1);
    rc("single clears go", OFF_CON1, 8'h07);
    wr(OFF_TMRL, 8'h00);
    wr(OFF_CON1, 8'hc8);
    repeat (3)
    begin
      sigLvl <= 1'b0;
      repeat (4) @(posedge sys_clk);
      sigLvl <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    rc("signal edges counted", OFF_TMRL, 8'h03);
    summarize();
  end
endmodule
`default_nettype wire
